/* sim/pvr_link_model.sv */
// ----------------------------------------------------------------------
// Link controller model: master of the register port
// ----------------------------------------------------------------------
module pvr_link_model
    import pvr_pkg::*;
(
    input wire logic core_clk_i, // Core clock
    input wire logic [7:0] rdata_i, // Read data from the block
    output pvr_pkg::pvr_req_t req_o // Register request
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus shows inverted leftovers so stale values never look valid
    initial req_o = '0;

    // One write cycle, strobe taken at the second edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        req_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // One read cycle; data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        req_o <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata_i;
    endtask

    // Write then read with no idle cycle between the two strobes
    task automatic wr_rd(input logic [3:0] wa, input logic [7:0] wd,
                         input logic [3:0] ra, output logic [7:0] d);
        @(posedge core_clk_i);
        req_o <= '{addr: wa, wdata: wd, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        req_o <= '{addr: ra, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk_i);
        req_o <= '{addr: ~ra, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata_i;
    endtask
endmodule

/* sim/test_pvr_regs.sv */
// ----------------------------------------------------------------------
// Register bank bench
// ----------------------------------------------------------------------
module test_pvr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pvr_pkg::*;

    localparam logic [23:0] OUI = 24'h5a_3c_96; // Arbitrary value
    localparam logic [23:0] PROD = 24'h69_c3_a5; // Arbitrary value
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    pvr_req_t req;
    logic [2:0] straps = 3'h5;
    pvr_rx_t rx = '0;
    logic [1:0] pend_in = 2'h0;
    logic bus_rst = 1'b0;
    logic [7:0] rdata;
    logic [1:0] pend;
    logic [1:0] sid_spd;
    logic [2:0] sid_pwr;
    logic [2:0] peer_spd;
    int fails = 0;
    int num_checks = 0;

    // 40 MHz core clock
    always #12.5 core_clk = ~core_clk;

    pvr_regs #(.MAKER_OUI(OUI), .PRODUCT_CODE(PROD)) u_pvr_regs (
        .core_clk_i(core_clk), .rstn_i(rstn), .req_i(req),
        .power_class_straps_i(straps), .rx_i(rx), .pending_i(pend_in),
        .bus_reset_i(bus_rst), .rdata_o(rdata), .pending_o(pend),
        .selfid_speed_field_o(sid_spd), .selfid_pwr_o(sid_pwr),
        .peer_speed_o(peer_spd));

    pvr_link_model u_pvr_link_model (
        .core_clk_i(core_clk), .rdata_i(rdata), .req_o(req));

    task automatic finish_test;
        if (fails == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_pvr_link_model.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask

    // Back-to-back write and read, no idle cycle between them
    task automatic wr_rd_chk(input logic [3:0] wa, input logic [7:0] wd,
                             input logic [3:0] ra, input logic [7:0] e);
        logic [7:0] d;
        u_pvr_link_model.wr_rd(wa, wd, ra, d);
        chk($sformatf("reg %h", ra), e, d);
    endtask

    // Self-ID fields lag a write by two edges
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // Raise both requests, then report one packet of nb bits
    task automatic pkt(input logic [7:0] nb, input logic [1:0] e);
        @(posedge core_clk);
        pend_in <= 2'h3;
        @(posedge core_clk);
        pend_in <= 2'h0;
        rx <= '{valid: 1'b1, nbits: nb};
        @(posedge core_clk);
        rx <= '0;
        #1;
        chk("pending", {6'h0, e}, {6'h0, pend});
    endtask

    // Hardware reset, then look at the self-ID defaults
    task automatic hw_reset;
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        settle();
        chk("sid speed", 8'h02, {6'h0, sid_spd});
        chk("peer speed", 8'h02, {5'h0, peer_spd});
        chk("sid pwr", {5'h0, straps}, {5'h0, sid_pwr});
    endtask

    // Watchdog sized well past the few hundred cycles the tests need
    initial
    begin
        #200000;
        fails++;
        finish_test();
    end

    initial
    begin
        hw_reset();
        u_pvr_link_model.wr(4'h7, 8'h00);
        rd_chk(4'h8, 8'h00);
        u_pvr_link_model.wr(4'h7, 8'h20);
        rd_chk(4'h8, 8'h01);
        rd_chk(4'h9, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            rd_chk(4'(10 + i), OUI[23 - 8 * i -: 8]);
            rd_chk(4'(13 + i), PROD[23 - 8 * i -: 8]);
        end
        u_pvr_link_model.wr(4'h7, 8'he0);
        rd_chk(4'h8, 8'h02);
        rd_chk(4'h7, 8'he0);
        for (int i = 9; i < 16; i++)
        begin
            u_pvr_link_model.wr(4'(i), 8'hff);
            rd_chk(4'(i), 8'h00);
        end
        rd_chk(4'h8, 8'h02);
        pkt(8'h00, 2'h0);
        pkt(8'h05, 2'h0);
        pkt(8'h08, 2'h3);
        pkt(8'h09, 2'h0);
        u_pvr_link_model.wr(4'h8, 8'h82);
        rd_chk(4'h8, 8'h82);
        pkt(8'h00, 2'h3);
        pkt(8'h05, 2'h3);
        pkt(8'h08, 2'h3);
        pkt(8'h09, 2'h0);
        for (int s = 0; s < 3; s++)
        begin
            u_pvr_link_model.wr(4'h8, 8'(s));
            settle();
            chk("sid speed", 8'(s), {6'h0, sid_spd});
            chk("peer speed", 8'h02, {5'h0, peer_spd});
            rd_chk(4'h8, 8'(s));
        end
        wr_rd_chk(4'h8, 8'h81, 4'h8, 8'h81);
        @(posedge core_clk);
        bus_rst <= 1'b1;
        @(posedge core_clk);
        bus_rst <= 1'b0;
        rd_chk(4'h8, 8'h81);
        for (int c = 0; c < 8; c++)
        begin
            u_pvr_link_model.wr(4'h4, 8'(c));
            settle();
            chk("sid pwr", 8'(c), {5'h0, sid_pwr});
            rd_chk(4'h4, 8'(c));
        end
        @(posedge core_clk);
        straps <= 3'h2;
        hw_reset();
        wr_rd_chk(4'h7, 8'h20, 4'h8, 8'h01);
        wr_rd_chk(4'h8, 8'hff, 4'h8, 8'h01);
        u_pvr_link_model.wr(4'h7, 8'he0);
        rd_chk(4'h8, 8'h02);
        finish_test();
    end
endmodule

/* verilog/pvr_pkg.sv */
package pvr_pkg;

    // ------------------------------------------------------------------
    // Register addresses and pages
    // ------------------------------------------------------------------
    localparam logic [3:0] PVR_ADDR_PAGE_SEL = 4'h7;
    localparam logic [3:0] PVR_ADDR_PWR_REG = 4'h4;
    localparam logic [3:0] PVR_ADDR_PAGED_LO = 4'h8;
    localparam logic [3:0] PVR_ADDR_COMPLIANCE = 4'h8;
    localparam logic [3:0] PVR_ADDR_OUI_HIGH = 4'ha;
    localparam logic [3:0] PVR_ADDR_OUI_MID = 4'hb;
    localparam logic [3:0] PVR_ADDR_OUI_LOW = 4'hc;
    localparam logic [3:0] PVR_ADDR_PROD_HIGH = 4'hd;
    localparam logic [3:0] PVR_ADDR_PROD_MID = 4'he;
    localparam logic [3:0] PVR_ADDR_PROD_LOW = 4'hf;
    localparam logic [3:0] PVR_ADDR_VENDOR_CTRL = 4'h8;

    localparam logic [2:0] PVR_PAGE_ID = 3'h1;
    localparam logic [2:0] PVR_PAGE_VENDOR = 3'h7;

    // ------------------------------------------------------------------
    // Field positions within a register byte and within a self-ID packet
    // ------------------------------------------------------------------
    localparam int PVR_PAGE_SEL_LSB = 5;
    localparam int PVR_PWR_LSB = 0;
    localparam int PVR_NULL_KEEP_BIT = 7;
    localparam int PVR_LINK_SPEED_LSB = 0;
    localparam int PVR_SID_PWR_LSB = 21;
    localparam int PVR_SID_WIDTH = 32;

    // ------------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------------
    localparam logic [7:0] PVR_COMPLIANCE_VAL = 8'h01;
    localparam logic [2:0] PVR_PAGE_SEL_RST = 3'h0;
    localparam logic PVR_NULL_KEEP_RST = 1'b0;
    localparam logic [7:0] PVR_ACK_BITS = 8'h08;

    typedef enum logic [1:0]
    {
        PVR_SPD_S100 = 2'h0,
        PVR_SPD_S200 = 2'h1,
        PVR_SPD_S400 = 2'h2,
        PVR_SPD_BAD = 2'h3
    } pvr_speed_t;

    localparam pvr_speed_t PVR_LINK_SPEED_RST = PVR_SPD_S400;

    // Register port request from the link controller
    typedef struct packed
    {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pvr_req_t;

    // Received packet indication
    typedef struct packed
    {
        logic valid;
        logic [7:0] nbits;
    } pvr_rx_t;

endpackage

/* verilog/pvr_regs.sv */
// Overview of operation
// - Page selector in base register 7 picks the page seen at 8..15.
// - Page 1 maps the identification registers onto addresses 8..15.
// - Address 8 of page 1 reads the fixed compliance level 01h.
// - A fixed 24-bit maker OUI reads from 10..12, MSB at 10.
// - A fixed 24-bit product code reads from 13..15, MSB at 13.
// - Page 7 maps the vendor-dependent control register at 8; 9..15 read zero.
// - With the null flag set, only packets over 8 bits clear requests.
// - With the null flag clear, any non-ack packet clears requests.
// - The null flag is read/write, zero after hardware reset only.
// - Link speed is a 2-bit field, 00/01/10, 11 never written.
// - Link speed is copied into the speed field of every self-ID.
// - Peer PHYs always see S400 capability during self-ID.
// - Link speed resets to S400 and ignores bus reset.
// - Power-class straps give the default self-ID power field 21..23.
// - Straps load after reset; a later register 4 write replaces them.
// - The 3-bit power code is reported exactly as held.
//
// The implementer's own choice: the strobed register port.
module pvr_regs #(
    parameter logic [23:0] MAKER_OUI = 24'h12_34_56, // Arbitrary value
    parameter logic [23:0] PRODUCT_CODE = 24'hab_cd_ef // Arbitrary value
) (
    input wire logic core_clk_i, // 40 MHz core clock
    input wire logic rstn_i, // Hardware reset, async, active low
    input wire pvr_pkg::pvr_req_t req_i, // Register access request
    input wire logic [2:0] power_class_straps_i, // Power-class straps
    input wire pvr_pkg::pvr_rx_t rx_i, // Received packet report
    input wire logic [1:0] pending_i, // Fair/priority requests raised
    input wire logic bus_reset_i, // Bus reset, touches no state here
    output logic [7:0] rdata_o, // Read data, one cycle after strobe
    output logic [1:0] pending_o, // Fair/priority requests pending
    output logic [1:0] selfid_speed_field_o, // Speed in self-ID
    output logic [2:0] selfid_pwr_o, // Power class in self-ID
    output logic [2:0] peer_speed_o // Speed signalled to peer PHYs
);
    import pvr_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [2:0] page_sel;
    logic null_packet_keep_requests;
    pvr_speed_t link_speed;
    logic [2:0] pwr_class;
    logic strap_loaded;
    logic [7:0] next_rdata;
    logic clear_req;

    // Paged view is only active for the upper half of the address space
    function automatic logic is_paged(input logic [3:0] a);
        return a >= PVR_ADDR_PAGED_LO;
    endfunction

    // Vendor control decode, shared by the write and read paths
    function automatic logic hits_vendor_ctrl(input logic [2:0] pg,
        input logic [3:0] a);
        return pg == PVR_PAGE_VENDOR && a == PVR_ADDR_VENDOR_CTRL;
    endfunction

    // ------------------------------------------------------------------
    // Page selector
    // ------------------------------------------------------------------
    // Bus reset deliberately not used: selection survives it
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            page_sel <= PVR_PAGE_SEL_RST;
        else if (req_i.wr && req_i.addr == PVR_ADDR_PAGE_SEL)
            page_sel <= req_i.wdata[PVR_PAGE_SEL_LSB +: 3];
    end

    // Vendor control: null flag and link speed, hardware reset only
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            null_packet_keep_requests <= PVR_NULL_KEEP_RST;
            link_speed <= PVR_LINK_SPEED_RST;
        end
        else if (req_i.wr && hits_vendor_ctrl(page_sel, req_i.addr))
        begin
            null_packet_keep_requests <= req_i.wdata[PVR_NULL_KEEP_BIT];
            // Code 11 is the writer's fault; stored as given
            link_speed <= pvr_speed_t'(
                req_i.wdata[PVR_LINK_SPEED_LSB +: 2]);
        end
    end

    // ------------------------------------------------------------------
    // Power class: straps caught on the first clock after release
    // ------------------------------------------------------------------
    // Async reset may only load constants, so the strap load is clocked
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pwr_class <= 3'h0;
            strap_loaded <= 1'b0;
        end
        else if (req_i.wr && req_i.addr == PVR_ADDR_PWR_REG)
        begin
            pwr_class <= req_i.wdata[PVR_PWR_LSB +: 3];
            strap_loaded <= 1'b1;
        end
        else if (!strap_loaded)
        begin
            pwr_class <= power_class_straps_i;
            strap_loaded <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        if (req_i.addr == PVR_ADDR_PAGE_SEL)
            next_rdata[PVR_PAGE_SEL_LSB +: 3] = page_sel;
        else if (req_i.addr == PVR_ADDR_PWR_REG)
            next_rdata[PVR_PWR_LSB +: 3] = pwr_class;
        else if (is_paged(req_i.addr) && page_sel == PVR_PAGE_ID)
        begin
            case (req_i.addr)
                PVR_ADDR_COMPLIANCE: next_rdata = PVR_COMPLIANCE_VAL;
                PVR_ADDR_OUI_HIGH: next_rdata = MAKER_OUI[23:16];
                PVR_ADDR_OUI_MID: next_rdata = MAKER_OUI[15:8];
                PVR_ADDR_OUI_LOW: next_rdata = MAKER_OUI[7:0];
                PVR_ADDR_PROD_HIGH: next_rdata = PRODUCT_CODE[23:16];
                PVR_ADDR_PROD_MID: next_rdata = PRODUCT_CODE[15:8];
                PVR_ADDR_PROD_LOW: next_rdata = PRODUCT_CODE[7:0];
                default: next_rdata = 8'h00;
            endcase
        end
        else if (hits_vendor_ctrl(page_sel, req_i.addr))
        begin
            next_rdata[PVR_NULL_KEEP_BIT] = null_packet_keep_requests;
            next_rdata[PVR_LINK_SPEED_LSB +: 2] = link_speed;
        end
    end

    // Read data valid only in the cycle after the read strobe
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else if (req_i.rd)
            rdata_o <= next_rdata;
        else
            rdata_o <= 8'h00;
    end

    // ------------------------------------------------------------------
    // Arbitration request clearing on packet reception
    // ------------------------------------------------------------------
    always_comb
    begin
        if (null_packet_keep_requests)
            clear_req = rx_i.valid && rx_i.nbits > PVR_ACK_BITS;
        else
            clear_req = rx_i.valid && rx_i.nbits != PVR_ACK_BITS;
    end

    // New requests win over a clear in the same cycle
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            pending_o <= 2'h0;
        else if (clear_req)
            pending_o <= pending_i;
        else
            pending_o <= pending_o | pending_i;
    end

    // ------------------------------------------------------------------
    // Self-ID fields
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            selfid_speed_field_o <= PVR_LINK_SPEED_RST;
            selfid_pwr_o <= 3'h0;
            peer_speed_o <= 3'h0;
        end
        else
        begin
            selfid_speed_field_o <= link_speed;
            selfid_pwr_o <= pwr_class;
            peer_speed_o <= {1'b0, PVR_SPD_S400};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_vendor_wr;
        req_i.wr && page_sel == PVR_PAGE_VENDOR
            && req_i.addr == PVR_ADDR_VENDOR_CTRL;
    endsequence

    chk_page_select_wr: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr == PVR_ADDR_PAGE_SEL |=>
            page_sel == $past(req_i.wdata[7:5]))
        else $error("page select not stored");

    chk_compliance_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == PVR_ADDR_COMPLIANCE |=> rdata_o == 8'h01)
        else $error("compliance level wrong");

    chk_oui_high_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == 4'ha |=> rdata_o == MAKER_OUI[23:16])
        else $error("oui high byte wrong");

    chk_prod_high_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == 4'hd |=> rdata_o == PRODUCT_CODE[23:16])
        else $error("product high byte wrong");

    chk_vendor_ctrl_wr: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_vendor_wr ##1 req_i.rd && req_i.addr == 4'h8
            && page_sel == PVR_PAGE_VENDOR |=>
            rdata_o == {$past(req_i.wdata[7], 2), 5'h00,
                        $past(req_i.wdata[1:0], 2)})
        else $error("vendor control readback wrong");

    chk_keep_requests: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        null_packet_keep_requests && rx_i.valid
            && rx_i.nbits <= 8'h08 |=> (pending_o & $past(pending_o))
            == $past(pending_o))
        else $error("short packet cleared requests");

    chk_clear_requests: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        !null_packet_keep_requests && rx_i.valid && rx_i.nbits != 8'h08
            |=> pending_o == $past(pending_i))
        else $error("non-ack packet did not clear requests");

    chk_selfid_speed: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_vendor_wr |-> ##2 selfid_speed_field_o == $past(req_i.wdata[1:0], 2))
        else $error("self-ID speed not following link speed");

    chk_peer_s400: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        $rose(strap_loaded) |-> ##1 peer_speed_o == 3'h2 [*4])
        else $error("peer speed not S400");

    chk_reserved_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_VENDOR && req_i.addr > 4'h8
            |=> rdata_o == 8'h00)
        else $error("test register not zero");

    // Page 1 chosen by a write to the page selector
    sequence s_id_page_wr;
        req_i.wr && req_i.addr == PVR_ADDR_PAGE_SEL
            && req_i.wdata[PVR_PAGE_SEL_LSB +: 3] == PVR_PAGE_ID;
    endsequence

    // Compliance byte asked for straight after
    sequence s_compliance_rd;
        req_i.rd && req_i.addr == PVR_ADDR_COMPLIANCE;
    endsequence

    // A page change must already steer a read in the very next cycle
    chk_id_page_seq: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_id_page_wr ##1 s_compliance_rd |=> rdata_o == PVR_COMPLIANCE_VAL)
        else $error("page change not seen by next read");

    // Remaining identification bytes
    chk_oui_mid_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == PVR_ADDR_OUI_MID
            |=> rdata_o == MAKER_OUI[15:8])
        else $error("oui middle byte wrong");

    chk_oui_low_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == PVR_ADDR_OUI_LOW
            |=> rdata_o == MAKER_OUI[7:0])
        else $error("oui low byte wrong");

    chk_prod_mid_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == PVR_ADDR_PROD_MID
            |=> rdata_o == PRODUCT_CODE[15:8])
        else $error("product middle byte wrong");

    chk_prod_low_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == PVR_ADDR_PROD_LOW
            |=> rdata_o == PRODUCT_CODE[7:0])
        else $error("product low byte wrong");

    // The gap byte of the identification page holds nothing
    chk_id_reserved_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && page_sel == PVR_PAGE_ID
            && req_i.addr == PVR_ADDR_COMPLIANCE + 4'h1
            |=> rdata_o == 8'h00)
        else $error("identification gap byte not zero");

    // Pages other than 1 and 7 are not served by this block
    chk_other_page_zero: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && is_paged(req_i.addr) && page_sel != PVR_PAGE_ID
            && page_sel != PVR_PAGE_VENDOR |=> rdata_o == 8'h00)
        else $error("unserved page not zero");

    chk_page_sel_read: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.rd && req_i.addr == PVR_ADDR_PAGE_SEL
            |=> rdata_o[PVR_PAGE_SEL_LSB +: 3] == $past(page_sel))
        else $error("page select readback wrong");

    // Vendor control fields take the written bits
    chk_null_flag_wr: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_vendor_wr |=> null_packet_keep_requests
            == $past(req_i.wdata[PVR_NULL_KEEP_BIT]))
        else $error("null flag not stored");

    chk_speed_field_wr: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        s_vendor_wr |=> link_speed
            == $past(req_i.wdata[PVR_LINK_SPEED_LSB +: 2]))
        else $error("link speed not stored");

    // Bus reset must leave the vendor control byte alone
    chk_bus_reset_keep: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        bus_reset_i && !(req_i.wr && hits_vendor_ctrl(page_sel, req_i.addr))
            |=> $stable(link_speed) && $stable(null_packet_keep_requests))
        else $error("bus reset changed vendor control");

    // Power class: straps first, software writes after
    chk_pwr_class_wr: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        req_i.wr && req_i.addr == PVR_ADDR_PWR_REG
            |=> pwr_class == $past(req_i.wdata[PVR_PWR_LSB +: 3]))
        else $error("power class write not stored");

    chk_strap_load: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        !strap_loaded && !(req_i.wr && req_i.addr == PVR_ADDR_PWR_REG)
            |=> pwr_class == $past(power_class_straps_i))
        else $error("straps not loaded after reset");

    // Self-ID fields trail their registers by exactly one cycle
    chk_selfid_pwr: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        strap_loaded |=> selfid_pwr_o == $past(pwr_class))
        else $error("self-ID power class not reported as held");

    chk_selfid_copy: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        strap_loaded |=> selfid_speed_field_o == $past(link_speed))
        else $error("self-ID speed not a copy of link speed");

    chk_peer_always: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        strap_loaded |-> peer_speed_o == {1'b0, PVR_SPD_S400})
        else $error("peer speed left S400");

    // Request clearing, the two cases not covered above
    chk_long_pkt_clear: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        null_packet_keep_requests && rx_i.valid && rx_i.nbits > PVR_ACK_BITS
            |=> pending_o == $past(pending_i))
        else $error("long packet did not clear requests");

    chk_ack_keeps: assert property (
        @(posedge core_clk_i) disable iff (!rstn_i)
        !null_packet_keep_requests && rx_i.valid
            && rx_i.nbits == PVR_ACK_BITS
            |=> (pending_o & $past(pending_o)) == $past(pending_o))
        else $error("ack packet cleared requests");

endmodule
